// *** rtl/hbp_pkg.sv ***
package hbp_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int MEM_WORDS = 64;
    localparam logic [18:0] MEM_LIMIT = 19'h0_0100;
    localparam int WAIT_CYCLES = 2;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic STYLE_ACK = 1'h0;
    localparam logic STYLE_BE = 1'h1;
    localparam logic WIDTH_32 = 1'h0;
    localparam logic WIDTH_16 = 1'h1;
    // controller registers (AXI4-Lite byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_IRQ = 8'h14;
    localparam logic [7:0] REG_MASK = 8'h18;
    localparam int CTRL_GO = 0;
    localparam int CTRL_READ = 1;
    localparam int CTRL_STYLE = 2;
    localparam int CTRL_WIDTH = 3;
    localparam int CTRL_LANE = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hbp_pkg

// *** rtl/hbp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface hbp_if;
    logic chipSelectN;
    logic dataStrobeN;
    logic readWrite;
    logic [1:0] sizeLaneInputs;
    logic [18:0] addr;
    logic [31:0] dataHost;
    logic [31:0] dataDev;
    logic dataDevOeN;
    logic transferAckN;
    logic transferAckOeN;
    logic waitN;
    logic waitOeN;
    logic busErrorN;
    logic busErrorOeN;
    logic busStyleSelect;
    logic busWidthSelect;
    modport device (
        input chipSelectN, dataStrobeN, readWrite, sizeLaneInputs, addr, dataHost,
        input busStyleSelect, busWidthSelect,
        output dataDev, dataDevOeN, transferAckN, transferAckOeN, waitN, waitOeN,
        output busErrorN, busErrorOeN
    );
    modport host (
        output chipSelectN, dataStrobeN, readWrite, sizeLaneInputs, addr, dataHost,
        output busStyleSelect, busWidthSelect,
        input dataDev, dataDevOeN, transferAckN, transferAckOeN, waitN, waitOeN,
        input busErrorN, busErrorOeN
    );
endinterface : hbp_if
`default_nettype wire

// *** rtl/hbp_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module hbp_device (
    input wire logic clk,
    input wire logic nrst,
    hbp_if.device bus,
    output logic accessPulse,
    output logic errorPulse
);
    // ************************************************
    // state
    // ************************************************
    typedef enum logic [3:0] {
        IDLE = 4'b0001,
        WAITING = 4'b0010,
        DONE = 4'b0100,
        FAULT = 4'b1000
    } hbp_dstate_type;
    hbp_dstate_type state_reg;
    logic [31:0] mem [hbp_pkg::MEM_WORDS];
    logic [1:0] waitCnt_reg;
    logic [31:0] rdData_reg;
    logic [3:0] lanes;
    logic sel;
    logic badAddr;
    logic [5:0] wordIdx;

    assign sel = !bus.chipSelectN && !bus.dataStrobeN;
    assign badAddr = bus.addr >= hbp_pkg::MEM_LIMIT;
    // 16-bit mode ignores A0 and the upper data lines
    assign wordIdx = bus.busWidthSelect == hbp_pkg::WIDTH_16 ? bus.addr[7:2] : bus.addr[7:2];

    // ************************************************
    // byte lane decode
    // ************************************************
    always_comb begin
        lanes = 4'h0;
        if (bus.busStyleSelect == hbp_pkg::STYLE_BE) begin
            lanes[0] = !bus.sizeLaneInputs[0];
            lanes[1] = !bus.sizeLaneInputs[1];
            if (bus.busWidthSelect == hbp_pkg::WIDTH_32) begin
                lanes[2] = !bus.addr[0];
                lanes[3] = !bus.addr[1];
            end
        end else if (bus.busWidthSelect == hbp_pkg::WIDTH_16) begin
            lanes[0] = !bus.sizeLaneInputs[0];
            lanes[1] = !bus.sizeLaneInputs[1];
        end else begin
            unique case (bus.sizeLaneInputs)
                hbp_pkg::SIZE_BYTE: lanes = 4'h1 << bus.addr[1:0];
                hbp_pkg::SIZE_WORD: lanes = bus.addr[1] ? 4'hC : 4'h3;
                default: lanes = 4'hF;
            endcase
        end
    end

    // ************************************************
    // transfer sequencing
    // ************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= IDLE;
            waitCnt_reg <= 2'h0;
        end else begin
            unique case (state_reg)
                IDLE: if (sel) begin
                    waitCnt_reg <= 2'(hbp_pkg::WAIT_CYCLES);
                    state_reg <= WAITING;
                end
                WAITING: if (!sel) begin
                    state_reg <= IDLE;
                end else if (waitCnt_reg != 2'h0) begin
                    waitCnt_reg <= waitCnt_reg - 2'h1;
                end else begin
                    state_reg <= badAddr ? FAULT : DONE;
                end
                DONE, FAULT: if (!sel) state_reg <= IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (state_reg == WAITING && sel && waitCnt_reg == 2'h0 && !badAddr) begin
            if (!bus.readWrite) begin
                for (int i = 0; i < 4; i++) begin
                    if (lanes[i]) mem[wordIdx][8*i +: 8] <= bus.dataHost[8*i +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdData_reg <= 32'h0000_0000;
        end else if (state_reg == WAITING && waitCnt_reg == 2'h0) begin
            rdData_reg <= badAddr ? 32'h0000_0000 : mem[wordIdx];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accessPulse <= 1'b0;
            errorPulse <= 1'b0;
        end else begin
            accessPulse <= state_reg == WAITING && sel && waitCnt_reg == 2'h0;
            errorPulse <= state_reg == WAITING && sel && waitCnt_reg == 2'h0 && badAddr;
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    logic active;
    assign active = sel && state_reg != IDLE;
    assign bus.dataDev = rdData_reg;
    assign bus.dataDevOeN = !(active && bus.readWrite && (state_reg == DONE || state_reg == FAULT));
    assign bus.waitN = !(state_reg == WAITING);
    assign bus.waitOeN = !active;
    assign bus.busErrorN = !(state_reg == FAULT);
    assign bus.busErrorOeN = !active;
    // ack: suppressed on error only in ack-style mode
    assign bus.transferAckN = !(state_reg == DONE ||
        (state_reg == FAULT && bus.busStyleSelect == hbp_pkg::STYLE_BE));
    assign bus.transferAckOeN = !active;
    // width select defaults low when open: pull-down lives on the wire
endmodule : hbp_device
`default_nettype wire

// *** rtl/hbp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module hbp_host (
    input wire logic clk,
    input wire logic nrst,
    hbp_if.host bus,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq
);
    // ************************************************
    // state and registers
    // ************************************************
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_ACT = 3'b010,
        H_END = 3'b100
    } hbp_hstate_type;
    hbp_hstate_type state_reg;
    logic [7:0] ctrl_reg;
    logic [18:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic busy_reg;
    logic lastErr_reg;
    logic [1:0] irq_reg;
    logic [1:0] mask_reg;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awA_reg;
    logic [31:0] wD_reg;
    logic ackSeen;
    logic errSeen;
    logic doWrite;
    logic goPulse;
    logic [1:0] irqSet;

    // ************************************************
    // axi4-lite slave
    // ************************************************
    // address and data may land in either order; the response waits for both halves
    assign awready = !awHeld_reg && !bvalid;
    assign wready = !wHeld_reg && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
    assign goPulse = doWrite && awA_reg == hbp_pkg::REG_CTRL && wD_reg[hbp_pkg::CTRL_GO] && !busy_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awA_reg <= 8'h00;
            wD_reg <= 32'h0000_0000;
            bvalid <= 1'b0;
            bresp <= hbp_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld_reg <= 1'b1;
                awA_reg <= awaddr[7:0];
            end
            if (wvalid && wready) begin
                wHeld_reg <= 1'b1;
                wD_reg <= wdata;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid <= 1'b1;
                // a write past the last register still answers, with an error code
                bresp <= awA_reg > hbp_pkg::REG_MASK ? hbp_pkg::RESP_SLVERR : hbp_pkg::RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ************************************************
    // register file
    // ************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= 8'h00;
            addr_reg <= 19'h0_0000;
            wdata_reg <= 32'h0000_0000;
            mask_reg <= 2'h0;
        end else if (doWrite) begin
            unique case (awA_reg)
                hbp_pkg::REG_CTRL: begin
                    // mode and lane bits drive the pins, so they stay frozen while a cycle runs
                    if (!busy_reg) ctrl_reg <= {wD_reg[7:1], 1'b0};
                end
                hbp_pkg::REG_ADDR: addr_reg <= wD_reg[18:0];
                hbp_pkg::REG_WDATA: wdata_reg <= wD_reg;
                hbp_pkg::REG_MASK: mask_reg <= wD_reg[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= hbp_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= hbp_pkg::RESP_OKAY;
            unique case (araddr[7:0])
                hbp_pkg::REG_CTRL: rdata <= {24'h00_0000, ctrl_reg};
                hbp_pkg::REG_ADDR: rdata <= {13'h0000, addr_reg};
                hbp_pkg::REG_WDATA: rdata <= wdata_reg;
                hbp_pkg::REG_RDATA: rdata <= rdata_reg;
                hbp_pkg::REG_STATUS: rdata <= {30'h0000_0000, lastErr_reg, busy_reg};
                hbp_pkg::REG_IRQ: rdata <= {30'h0000_0000, irq_reg};
                hbp_pkg::REG_MASK: rdata <= {30'h0000_0000, mask_reg};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= hbp_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ************************************************
    // parallel bus cycle
    // ************************************************
    assign ackSeen = bus.transferAckOeN == 1'b0 && !bus.transferAckN;
    assign errSeen = bus.busErrorOeN == 1'b0 && !bus.busErrorN;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= H_IDLE;
            busy_reg <= 1'b0;
            lastErr_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                H_IDLE: if (goPulse) begin
                    busy_reg <= 1'b1;
                    lastErr_reg <= 1'b0;
                    state_reg <= H_ACT;
                end
                // wait is not sampled; only ack or error ends the cycle
                H_ACT: if (ackSeen || errSeen) begin
                    lastErr_reg <= errSeen;
                    if (ctrl_reg[hbp_pkg::CTRL_READ] && bus.dataDevOeN == 1'b0) rdata_reg <= bus.dataDev;
                    state_reg <= H_END;
                end
                // one edge with the strobe high lets the device drop back to idle
                H_END: begin
                    busy_reg <= 1'b0;
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    // ************************************************
    // pin drive
    // ************************************************
    assign bus.chipSelectN = state_reg != H_ACT;
    assign bus.dataStrobeN = state_reg != H_ACT;
    assign bus.readWrite = ctrl_reg[hbp_pkg::CTRL_READ];
    assign bus.busStyleSelect = ctrl_reg[hbp_pkg::CTRL_STYLE];
    assign bus.busWidthSelect = ctrl_reg[hbp_pkg::CTRL_WIDTH];
    // lane bits carry size or active-low strobes/enables as the mode reads them
    assign bus.sizeLaneInputs = ctrl_reg[hbp_pkg::CTRL_LANE +: 2];
    // 16-bit: A0 and upper data held low be 32-bit: A1/A0 are enables
    assign bus.addr = ctrl_reg[hbp_pkg::CTRL_WIDTH] ? {addr_reg[18:1], 1'b0} : addr_reg;
    assign bus.dataHost = ctrl_reg[hbp_pkg::CTRL_WIDTH] ? {16'h0000, wdata_reg[15:0]} : wdata_reg;

    // ************************************************
    // interrupts
    // ************************************************
    assign irqSet = {state_reg == H_ACT && errSeen,
        state_reg == H_ACT && (ackSeen || errSeen)};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 2'h0;
        end else begin
            // set wins over a write-one clear in the same cycle
            if (doWrite && awA_reg == hbp_pkg::REG_IRQ) begin
                irq_reg <= (irq_reg & ~wD_reg[1:0]) | irqSet;
            end else begin
                irq_reg <= irq_reg | irqSet;
            end
        end
    end
    // level output: high until software clears or masks every cause
    assign irq = |(irq_reg & mask_reg);
endmodule : hbp_host
`default_nettype wire

// *** testbench/hbp_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ********************************
// link protocol checks
// ********************************
module hbp_link_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic chipSelectN,
    input wire logic dataStrobeN,
    input wire logic readWrite,
    input wire logic [18:0] addr,
    input wire logic dataDevOeN,
    input wire logic transferAckN,
    input wire logic transferAckOeN,
    input wire logic waitN,
    input wire logic waitOeN,
    input wire logic busErrorN,
    input wire logic busErrorOeN,
    input wire logic busStyleSelect
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // the device releases its outputs as soon as the strobe goes; the check still waits for two idle edges
    chk_idle_release: assert property (chipSelectN ##1 chipSelectN |->
        transferAckOeN && waitOeN && busErrorOeN && dataDevOeN)
        else $error("link outputs driven while not selected");
    chk_wait_first: assert property ($fell(chipSelectN | dataStrobeN) |=> !waitN && !waitOeN)
        else $error("wait not asserted at access start");
    chk_wait_length: assert property ($fell(chipSelectN | dataStrobeN) |=> (!waitN)[*3] ##1
        ((!transferAckN && !transferAckOeN) || (!busErrorN && !busErrorOeN)))
        else $error("wait length or completion wrong");
    // the acknowledge stands for as long as the host still selects
    chk_ack_holds: assert property (!transferAckN && !transferAckOeN |=>
        chipSelectN || dataStrobeN || (!transferAckN && !transferAckOeN))
        else $error("acknowledge dropped while selected");
    chk_no_ack_err: assert property (busStyleSelect == hbp_pkg::STYLE_ACK && !busErrorN && !busErrorOeN
        |-> transferAckN || transferAckOeN)
        else $error("acknowledge with bus error in ack style");
    chk_be_ack_err: assert property (busStyleSelect == hbp_pkg::STYLE_BE && !busErrorN && !busErrorOeN
        |-> !transferAckN && !transferAckOeN)
        else $error("no acknowledge with bus error in byte-enable style");
    chk_err_unmapped: assert property (!busErrorN && !busErrorOeN |-> addr >= hbp_pkg::MEM_LIMIT)
        else $error("bus error on mapped address");
    chk_ack_mapped: assert property (busStyleSelect == hbp_pkg::STYLE_ACK && !transferAckN
        && !transferAckOeN |-> addr < hbp_pkg::MEM_LIMIT)
        else $error("acknowledge on unmapped address");
    chk_read_drive: assert property (!dataDevOeN |-> $past(readWrite) && !$past(chipSelectN))
        else $error("data driven outside a read");
    cover property (!transferAckN && !transferAckOeN && readWrite);
    cover property (!transferAckN && !transferAckOeN && !readWrite);
    cover property (!busErrorN && !busErrorOeN && busStyleSelect == hbp_pkg::STYLE_BE);
endmodule : hbp_link_checker
`default_nettype wire

// *** testbench/test_host_bus_port_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_host_bus_port_control;
    typedef struct packed {
        logic rd; logic style; logic width; logic [1:0] lane;
        logic [18:0] a; logic [31:0] d; logic err; logic chk;
    } hbp_row_type;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, irq;
    logic accessPulse, errorPulse;
    logic [31:0] awaddr, wdata, araddr, rdata, st, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int failures, n_checks, cycles, nAcc, nErr, expErr;
    hbp_row_type rows [13];
    hbp_if busIf();
    hbp_host hbp_host_inst (.clk(clk), .nrst(nrst), .bus(busIf.host), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
    hbp_device hbp_device_inst (.clk(clk), .nrst(nrst), .bus(busIf.device), .accessPulse(accessPulse),
        .errorPulse(errorPulse));
    hbp_link_checker hbp_link_checker_inst (.clk(clk), .nrst(nrst), .chipSelectN(busIf.chipSelectN),
        .dataStrobeN(busIf.dataStrobeN), .readWrite(busIf.readWrite), .addr(busIf.addr),
        .dataDevOeN(busIf.dataDevOeN), .transferAckN(busIf.transferAckN), .transferAckOeN(busIf.transferAckOeN),
        .waitN(busIf.waitN), .waitOeN(busIf.waitOeN), .busErrorN(busIf.busErrorN),
        .busErrorOeN(busIf.busErrorOeN), .busStyleSelect(busIf.busStyleSelect));
    // ********************************
    // helpers
    // ********************************
    task end_of_test;
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= {24'h00_0000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        resp = bresp;
    endtask : axi_write
    task axi_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        araddr <= {24'h00_0000, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
    endtask : axi_read
    // one link access ordered through the controller registers
    task run(input hbp_row_type r);
        axi_write(hbp_pkg::REG_ADDR, {13'h0000, r.a});
        axi_write(hbp_pkg::REG_WDATA, r.d);
        axi_write(hbp_pkg::REG_CTRL, {26'h000_0000, r.lane, r.width, r.style, r.rd, 1'b1});
        do axi_read(hbp_pkg::REG_STATUS, st); while (st[0] !== 1'b0);
        axi_read(hbp_pkg::REG_RDATA, rd);
        expErr += r.err;
    endtask : run
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        nAcc <= nAcc + accessPulse;
        nErr <= nErr + errorPulse;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        {failures, n_checks, cycles, nAcc, nErr, expErr} = '0;
        rows[0] = {5'h00, 19'h0_0010, 32'hA5A5_5A5A, 2'h0}; // ack 32 long write
        rows[1] = {5'h10, 19'h0_0010, 32'hA5A5_5A5A, 2'h1}; // ack 32 long read back
        rows[2] = {5'h00, 19'h0_00FC, 32'h1234_5678, 2'h0};
        rows[3] = {5'h18, 19'h0_00FC, 32'h1234_5678, 2'h1}; // byte-enable 32 read
        rows[4] = {5'h01, 19'h0_00FE, 32'hC3C3_C3C3, 2'h0}; // ack 32 byte size, lane 2 only
        rows[5] = {5'h05, 19'h0_00FC, 32'h0000_9900, 2'h0}; // ack 16, upper strobe only
        rows[6] = {5'h0B, 19'h0_00FD, 32'h8800_0000, 2'h0}; // byte-enable 32, enable 3 only
        rows[7] = {5'h10, 19'h0_00FC, 32'h88C3_9978, 2'h1}; // the three partial writes above
        rows[8] = {5'h04, 19'h0_0100, 32'h0000_5555, 2'h2}; // ack 16, first unmapped
        rows[9] = {5'h18, 19'h0_0100, 32'h0000_0000, 2'h3};
        rows[10] = {5'h0C, 19'h0_0020, 32'h0000_1234, 2'h0}; // byte-enable 16, both lanes
        rows[11] = {5'h0F, 19'h7_FFFE, 32'h0000_0000, 2'h2}; // byte-enable 16, no lane
        rows[12] = {5'h02, 19'h0_0020, 32'h0000_00C3, 2'h0}; // ack 32 word size
        repeat (20) @(posedge clk);
        check("released in reset", {busIf.transferAckOeN, busIf.waitOeN, busIf.busErrorOeN, irq}, 4'hE);
        nrst <= 1'b1;
        axi_read(hbp_pkg::REG_STATUS, st);
        check("status after reset", st, 32'h0000_0000);
        axi_write(hbp_pkg::REG_MASK, 32'h0000_0003);
        foreach (rows[i]) begin
            run(rows[i]);
            check("error status", {31'h0000_0000, st[1]}, {31'h0000_0000, rows[i].err});
            if (rows[i].chk) check("read data", rd, rows[i].d);
            axi_read(hbp_pkg::REG_IRQ, st);
            check("irq error bit", {31'h0000_0000, st[1]}, {31'h0000_0000, rows[i].err});
            check("irq level", {31'h0000_0000, irq}, 32'h0000_0001);
            axi_write(hbp_pkg::REG_IRQ, 32'h0000_0003);
            check("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
        end
        check("access count", nAcc, $size(rows));
        check("error count", nErr, expErr);
        axi_write(hbp_pkg::REG_MASK, 32'h0000_0000);
        run(rows[8]);
        check("masked irq", {31'h0000_0000, irq}, 32'h0000_0000);
        axi_write(hbp_pkg::REG_MASK, 32'h0000_0002);
        check("unmasked irq", {31'h0000_0000, irq}, 32'h0000_0001);
        axi_write(8'h40, 32'h0000_0001);
        check("unmapped write resp", {30'h0000_0000, resp}, {30'h0000_0000, hbp_pkg::RESP_SLVERR});
        axi_read(8'h40, rd);
        check("unmapped read", {resp, rd[29:0]}, {hbp_pkg::RESP_SLVERR, 30'h0000_0000});
        // reset in mid-access must release the link at once, without a clock edge
        axi_write(hbp_pkg::REG_CTRL, 32'h0000_0003);
        repeat (2) @(posedge clk);
        nrst <= 1'b0;
        #1 check("async release", {busIf.transferAckOeN, busIf.waitOeN, busIf.busErrorOeN, irq}, 4'hE);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        axi_read(hbp_pkg::REG_STATUS, st);
        check("status after second reset", st, 32'h0000_0000);
        run(rows[8]);
        check("access after second reset", {31'h0000_0000, st[1]}, 32'h0000_0001);
        end_of_test();
    end
endmodule : test_host_bus_port_control
`default_nettype wire
